// ===== igm_port.sv
`timescale 1ns/1ps
`include "igm_params.svh"
module igm_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic port_enable,
  input wire logic [3:0] port_mode_sel,
  input wire logic general_call_en,
  input wire logic clock_release,
  input wire logic start_enable_set,
  input wire logic stop_enable_set,
  input wire logic [7:0] addr_reload_reg,
  input wire logic buf_wr,
  input wire igm_pkg::igm_byte_t buf_wr_data,
  input wire logic ua_update,
  input wire logic irq_clear,
  input wire logic write_collision_clear,
  input wire logic rx_ready,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic port_irq_flag,
  output logic write_collision,
  output logic buffer_full,
  output logic ack_received_status,
  output logic addr_update_needed,
  output logic start_enable,
  output logic stop_enable,
  output logic start_seen,
  output logic stop_seen,
  output logic rx_valid,
  output igm_pkg::igm_byte_t rx_data
);
  import igm_pkg::*;
  igm_state_t st_q;
  logic [`IGM_RELOAD_W-1:0] cnt_q;
  logic cnt_run_q;
  logic phase_q;
  logic [3:0] bit_q;
  igm_byte_t shift_reg;
  igm_byte_t xfer_buffer;
  logic hold_q, scl_drv_q, sda_drv_q;
  logic irq_q, write_collision_q, bf_q, ack_q, ua_q, sen_q, pen_q, s_q, p_q;
  logic rxv_q;
  igm_byte_t rxd_q;
  logic scl_lv, scl_fell, sda_lv, sda_fell;
  logic scl_prev_q, sda_prev_q;
  logic gc_q;
  igm_pin_sync u_scl (.clk(clk), .reset(reset), .pin_in(scl_in), .level(scl_lv), .fell(scl_fell));
  igm_pin_sync u_sda (.clk(clk), .reset(reset), .pin_in(sda_in), .level(sda_lv), .fell(sda_fell));
  igm_stage_if stg ();
  igm_skid_buf u_buf (.clk(clk), .reset(reset), .st(stg.buf_side));
  function automatic logic is_gcall(input igm_byte_t a, input logic en);
    is_gcall = en && (a == `IGM_GCALL_ADDR);
  endfunction

  wire master = port_enable && (port_mode_sel == `IGM_MODE_MASTER);
  wire slave = port_enable && (port_mode_sel == `IGM_MODE_SLV7 || port_mode_sel == `IGM_MODE_SLV10);
  wire ten_bit = port_mode_sel == `IGM_MODE_SLV10;
  // Two decrements per 4-phase instruction cycle: every other clock
  wire tick = phase_q;
  wire cnt_zero = cnt_run_q && tick && (cnt_q == '0);
  wire [`IGM_RELOAD_W-1:0] reload_val = addr_reload_reg[`IGM_RELOAD_W-1:0];
  wire start_busy = (st_q == IGM_START1) || (st_q == IGM_START2);
  wire tx_busy = (st_q == IGM_TX_LOW) || (st_q == IGM_TX_HIGH);
  wire buf_take = buf_wr && master && !start_busy && !tx_busy && st_q == IGM_IDLE;
  wire collide = buf_wr && master && (start_busy || tx_busy);
  wire bus_start = sda_fell && scl_lv;
  wire bus_stop = sda_lv && !sda_prev_q && scl_lv;
  wire scl_rise = scl_lv && !scl_prev_q;
  wire slv_byte_done = (st_q == IGM_SLV_ADDR || st_q == IGM_SLV_DATA) && scl_rise && bit_q == 4'h7;
  wire gc_hit = (st_q == IGM_SLV_ADDR) && slv_byte_done && is_gcall({shift_reg[6:0], sda_lv}, general_call_en);
  wire ten_hdr = ten_bit && (st_q == IGM_SLV_ADDR) && slv_byte_done && (shift_reg[6:2] == 5'h1E) && !sda_lv;
  assign stg.in_valid = rxv_q;
  assign stg.in_data = rxd_q;
  assign stg.out_ready = rx_ready;

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = hold_q || scl_drv_q;
  assign sda_oe = sda_drv_q;
  assign port_irq_flag = irq_q;
  assign write_collision = write_collision_q;
  assign buffer_full = bf_q;
  assign ack_received_status = ack_q;
  assign addr_update_needed = ua_q;
  assign start_enable = sen_q;
  assign stop_enable = pen_q;
  assign start_seen = s_q;
  assign stop_seen = p_q;
  assign rx_valid = stg.out_valid;
  assign rx_data = stg.out_data;

  // Clock-release hold for slave clock synchronisation
  always_ff @(posedge clk) begin
    if (reset || !slave) begin
      hold_q <= 1'b0;
    end else if (!clock_release && !scl_lv) begin
      hold_q <= 1'b1;
    end else if (clock_release) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      phase_q <= ~phase_q;
      scl_prev_q <= scl_lv;
      sda_prev_q <= sda_lv;
    end
  end

  // Counter: loaded on demand, reloads at zero; stops at the end of START2, STOP3 and the ack bit, and on reset or when not in master mode
  always_ff @(posedge clk) begin
    if (reset || !master) begin
      cnt_q <= '0;
      cnt_run_q <= 1'b0;
    end else if (buf_take || (st_q == IGM_IDLE && (start_enable_set || stop_enable_set))) begin
      cnt_q <= reload_val;
      cnt_run_q <= 1'b1;
    end else if ((st_q == IGM_TX_HIGH || st_q == IGM_STOP2) && !scl_lv) begin
      cnt_q <= reload_val;
    end else if (cnt_zero) begin
      cnt_q <= reload_val;
      cnt_run_q <= !(st_q == IGM_START2 || st_q == IGM_STOP3
        || (st_q == IGM_TX_HIGH && bit_q == `IGM_BIT_ACK - 1'b1));
    end else if (cnt_run_q && tick) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= IGM_IDLE;
      bit_q <= 4'h0;
      shift_reg <= 8'h00;
      xfer_buffer <= 8'h00;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
      irq_q <= 1'b0;
      write_collision_q <= 1'b0;
      bf_q <= 1'b0;
      ack_q <= 1'b0;
      ua_q <= 1'b0;
      sen_q <= 1'b0;
      pen_q <= 1'b0;
      s_q <= 1'b0;
      p_q <= 1'b0;
      rxv_q <= 1'b0;
      rxd_q <= 8'h00;
      gc_q <= 1'b0;
    end else begin
      if (rxv_q && stg.in_ready) begin
        rxv_q <= 1'b0;
      end
      // Set wins over software clear
      if (irq_clear) begin
        irq_q <= 1'b0;
      end
      if (write_collision_clear) begin
        write_collision_q <= 1'b0;
      end
      if (collide) begin
        write_collision_q <= 1'b1;
      end
      if (ua_update) begin
        ua_q <= 1'b0;
      end
      if (!port_enable) begin
        s_q <= 1'b0;
        p_q <= 1'b0;
        st_q <= IGM_IDLE;
        scl_drv_q <= 1'b0;
        sda_drv_q <= 1'b0;
        sen_q <= 1'b0;
        pen_q <= 1'b0;
      end else begin
        if (bus_start) begin
          s_q <= 1'b1;
          p_q <= 1'b0;
        end
        if (bus_stop) begin
          p_q <= 1'b1;
          s_q <= 1'b0;
        end
        case (st_q)
          IGM_IDLE: begin
            if (master && start_enable_set && scl_lv && sda_lv) begin
              sen_q <= 1'b1;
              st_q <= IGM_START1;
            end else if (master && stop_enable_set) begin
              pen_q <= 1'b1;
              sda_drv_q <= 1'b1;
              st_q <= IGM_STOP1;
            end else if (buf_take) begin
              xfer_buffer <= buf_wr_data;
              shift_reg <= buf_wr_data;
              bf_q <= 1'b1;
              bit_q <= 4'h0;
              scl_drv_q <= 1'b1;
              sda_drv_q <= !buf_wr_data[7];
              st_q <= IGM_TX_LOW;
            end else if (slave && bus_start) begin
              bit_q <= 4'h0;
              st_q <= IGM_SLV_ADDR;
            end
          end
          IGM_START1: begin
            if (cnt_zero) begin
              sda_drv_q <= 1'b1;
              st_q <= IGM_START2;
            end
          end
          IGM_START2: begin
            if (cnt_zero) begin
              sen_q <= 1'b0;
              scl_drv_q <= 1'b1;
              irq_q <= 1'b1;
              st_q <= IGM_IDLE;
            end
          end
          IGM_TX_LOW: begin
            if (cnt_zero) begin
              scl_drv_q <= 1'b0;
              st_q <= IGM_TX_HIGH;
            end
          end
          IGM_TX_HIGH: begin
            if (cnt_zero && scl_lv) begin
              scl_drv_q <= 1'b1;
              if (bit_q == `IGM_BIT_ACK - 1'b1) begin
                ack_q <= sda_lv;
                irq_q <= 1'b1;
                st_q <= IGM_IDLE;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b1};
                bit_q <= bit_q + 1'b1;
                if (bit_q == `IGM_BIT_TX_LAST - 1'b1) begin
                  bf_q <= 1'b0;
                  sda_drv_q <= 1'b0;
                end else begin
                  sda_drv_q <= !shift_reg[6];
                end
                st_q <= IGM_TX_LOW;
              end
            end
          end
          IGM_STOP1: begin
            if (cnt_zero) begin
              scl_drv_q <= 1'b0;
              st_q <= IGM_STOP2;
            end
          end
          IGM_STOP2: begin
            if (cnt_zero && scl_lv) begin
              sda_drv_q <= 1'b0;
              st_q <= IGM_STOP3;
            end
          end
          IGM_STOP3: begin
            if (cnt_zero) begin
              pen_q <= 1'b0;
              irq_q <= 1'b1;
              st_q <= IGM_IDLE;
            end
          end
          IGM_SLV_ADDR, IGM_SLV_DATA: begin
            if (bus_stop || !slave) begin
              sda_drv_q <= 1'b0;
              st_q <= IGM_IDLE;
            end else if (scl_rise && bit_q < 4'h8) begin
              shift_reg <= {shift_reg[6:0], sda_lv};
              bit_q <= bit_q + 1'b1;
              if (gc_hit || (st_q == IGM_SLV_DATA && bit_q == 4'h7)) begin
                xfer_buffer <= {shift_reg[6:0], sda_lv};
                rxd_q <= {shift_reg[6:0], sda_lv};
                rxv_q <= 1'b1;
                bf_q <= 1'b1;
                gc_q <= gc_hit;
              end
            end else if (scl_fell && bit_q == 4'h8) begin
              sda_drv_q <= (st_q == IGM_SLV_DATA) || gc_q;
              bit_q <= 4'h9;
            end else if (scl_fell && bit_q == 4'h9) begin
              sda_drv_q <= 1'b0;
              bit_q <= 4'h0;
              if (gc_q) begin
                irq_q <= 1'b1;
                ua_q <= 1'b0;
                gc_q <= 1'b0;
                st_q <= IGM_SLV_DATA;
              end else if (st_q == IGM_SLV_DATA) begin
                irq_q <= 1'b1;
              end else begin
                st_q <= IGM_IDLE;
              end
            end
          end
          default: st_q <= IGM_IDLE;
        endcase
        if (!ten_bit) begin
          ua_q <= 1'b0;
        end else if (ten_hdr) begin
          ua_q <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== igm_params.svh
`ifndef IGM_PARAMS_SVH
`define IGM_PARAMS_SVH
`define IGM_RELOAD_W 7
`define IGM_GCALL_ADDR 8'h00
`define IGM_MODE_MASTER 4'h8
`define IGM_MODE_SLV7 4'h6
`define IGM_MODE_SLV10 4'h7
`define IGM_PHASES 2
`define IGM_BIT_TX_LAST 4'h8
`define IGM_BIT_ACK 4'h9
`endif

// ===== igm_pkg.sv
package igm_pkg;
  typedef enum logic [3:0] {
    IGM_IDLE, IGM_START1, IGM_START2, IGM_TX_LOW, IGM_TX_HIGH, IGM_STOP1, IGM_STOP2, IGM_STOP3,
    IGM_SLV_ADDR, IGM_SLV_DATA
  } igm_state_t;
  typedef logic [7:0] igm_byte_t;
endpackage

// ===== igm_stage_if.sv
`timescale 1ns/1ps
interface igm_stage_if;
  logic in_valid;
  logic in_ready;
  igm_pkg::igm_byte_t in_data;
  logic out_valid;
  logic out_ready;
  igm_pkg::igm_byte_t out_data;
  modport buf_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ===== igm_skid_buf.sv
`timescale 1ns/1ps
module igm_skid_buf (
  input wire logic clk,
  input wire logic reset,
  igm_stage_if.buf_side st
);
  import igm_pkg::*;
  igm_byte_t mem_q [2];
  logic [1:0] cnt_q;
  logic rd_q;
  logic wr_q;
  wire push = st.in_valid && st.in_ready;
  wire pop = st.out_valid && st.out_ready;
  assign st.in_ready = (cnt_q != 2'h2);
  assign st.out_valid = (cnt_q != 2'h0);
  assign st.out_data = mem_q[rd_q];
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= st.in_data;
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ===== igm_pin_sync.sv
`timescale 1ns/1ps
module igm_pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin_in,
  output logic level,
  output logic fell
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  // Level moves only when the second and third stage agree
  wire agree = (s2_q == s3_q);
  assign level = lvl_q;
  assign fell = agree && lvl_q && !s3_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end
endmodule

// ===== igm_port_chk.sv
`timescale 1ns/1ps
module igm_port_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic port_enable,
  input wire logic [3:0] port_mode_sel,
  input wire logic clock_release,
  input wire logic start_enable_set,
  input wire logic stop_enable_set,
  input wire logic [7:0] addr_reload_reg,
  input wire logic buf_wr,
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic port_irq_flag,
  input wire logic write_collision,
  input wire logic start_enable,
  input wire logic stop_enable,
  input wire logic start_seen,
  input wire logic stop_seen
);
  logic [9:0] hi_q;
  logic [9:0] lo_q;
  wire mst = port_enable && port_mode_sel == 4'h8;
  wire slv = port_enable && port_mode_sel != 4'h8;
  wire [9:0] per = ({3'h0, addr_reload_reg[6:0]} + 10'h001) << 1;
  // Saturating, so a long idle never wraps into a short count
  always_ff @(posedge clk) begin
    hi_q <= (scl_oe || reset) ? 10'h000 : hi_q + {9'h000, hi_q != 10'h3FF};
    lo_q <= (!scl_in || reset) ? 10'h000 : lo_q + {9'h000, lo_q != 10'h3FF};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  idle_release_a: assert property ($fell(reset) |-> !scl_oe && !sda_oe && !port_irq_flag)
    else $error("lines or flag active after reset");
  disable_clr_a: assert property (!port_enable |=> !start_seen && !stop_seen && !scl_oe && !sda_oe)
    else $error("disabled port not quiet");
  write_collision_a: assert property (start_enable && buf_wr |=> write_collision)
    else $error("write during start not flagged");
  start_done_a: assert property (mst && $fell(start_enable) |-> sda_oe && scl_oe && start_seen ##[0:2] port_irq_flag)
    else $error("start completion wrong");
  stop_done_a: assert property (mst && $fell(stop_enable) |-> !scl_oe && !sda_oe ##[0:2] port_irq_flag)
    else $error("stop completion wrong");
  seen_low_a: assert property (slv && $rose(scl_oe) |-> !clock_release && lo_q < 10'h008)
    else $error("slave hold without clock low");
  hold_keep_a: assert property (slv && scl_oe && !clock_release |=> scl_oe)
    else $error("slave hold dropped early");
  high_time_a: assert property (mst && $rose(scl_oe) |-> hi_q >= per)
    else $error("clock high time short");
  hold_byte_a: assert property (mst && scl_oe && port_irq_flag && !buf_wr && !stop_enable_set && !stop_enable
    && !start_enable_set |=> scl_oe)
    else $error("clock moved after byte done");
  cover property (mst && $fell(start_enable));
  cover property (mst && $fell(stop_enable));
  cover property (slv && $rose(scl_oe));
endmodule
bind igm_port igm_port_chk u_chk (.clk(clk), .reset(reset), .port_enable(port_enable),
  .port_mode_sel(port_mode_sel), .clock_release(clock_release), .start_enable_set(start_enable_set),
  .stop_enable_set(stop_enable_set), .addr_reload_reg(addr_reload_reg), .buf_wr(buf_wr), .scl_in(scl_in),
  .scl_oe(scl_oe), .sda_oe(sda_oe), .port_irq_flag(port_irq_flag), .write_collision(write_collision),
  .start_enable(start_enable), .stop_enable(stop_enable), .start_seen(start_seen), .stop_seen(stop_seen));

// ===== igm_bus_peer.sv
`timescale 1ns/1ps
module igm_bus_peer (
  input wire logic scl,
  input wire logic sda,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  input wire logic ack_en,
  input wire logic stretch,
  input wire logic hold,
  output logic scl_pull,
  output logic sda_pull
);
  logic m_scl = 1'b0;
  logic st_scl = 1'b0;
  logic m_sda = 1'b0;
  logic a_sda = 1'b0;
  int bitn = 0;
  assign scl_pull = m_scl | st_scl | hold;
  assign sda_pull = m_sda | a_sda;
  always @(negedge sda) if (scl) bitn = 0;
  // Released lines float to the pull-up level
  always @(negedge scl) begin
    bitn = bitn + 1;
    a_sda = ack_en && (bitn % 9) == 0;
    if (stretch) begin
      st_scl = 1'b1;
      #600 st_scl = 0;
    end
  end
  // Frame at the link rate; SCL rests high between frames
  always @(posedge go) begin
    m_sda = 1'b1;
    #200;
    for (int i = 0; i < 9; i++) begin
      m_scl = 1'b1;
      m_sda = (i < 8) && !tx_byte[7 - i];
      #200 m_scl = 1'b0;
      wait (scl);
      #200;
    end
    m_scl = 1'b1;
    m_sda = 1'b1;
    #200 m_scl = 1'b0;
    #200 m_sda = 1'b0;
  end
endmodule

// ===== i2c_gencall_master_brg_tb.sv
`timescale 1ns/1ps
module i2c_gencall_master_brg_tb;
  import igm_pkg::*;
  logic clk = 1'b0, reset = 1'b1, port_enable = 1'b0, general_call_en = 1'b0, clock_release = 1'b1;
  logic start_enable_set = 1'b0, stop_enable_set = 1'b0, buf_wr = 1'b0, ua_update = 1'b0;
  logic irq_clear = 1'b0, write_collision_clear = 1'b0, rx_ready = 1'b0;
  logic [3:0] port_mode_sel = 4'h0;
  logic [7:0] addr_reload_reg = 8'h00;
  igm_byte_t buf_wr_data = 8'h00;
  logic scl_out, scl_oe, sda_out, sda_oe, port_irq_flag, write_collision, buffer_full, ack_received_status;
  logic addr_update_needed, start_enable, stop_enable, start_seen, stop_seen, rx_valid;
  igm_byte_t rx_data;
  logic go = 1'b0, ack_en = 1'b0, stretch = 1'b0, hold = 1'b0, p_scl, p_sda;
  logic [7:0] tx_byte = 8'h00;
  logic [8:0] cap = 9'h000;
  int mismatches = 0, n_compared = 0;
  wire scl_in = !(scl_oe || p_scl);
  wire sda_in = !(sda_oe || p_sda);
  igm_port dut (.clk(clk), .reset(reset), .port_enable(port_enable), .port_mode_sel(port_mode_sel),
    .general_call_en(general_call_en), .clock_release(clock_release), .start_enable_set(start_enable_set),
    .stop_enable_set(stop_enable_set), .addr_reload_reg(addr_reload_reg), .buf_wr(buf_wr),
    .buf_wr_data(buf_wr_data), .ua_update(ua_update), .irq_clear(irq_clear), .write_collision_clear(write_collision_clear),
    .rx_ready(rx_ready), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .port_irq_flag(port_irq_flag), .write_collision(write_collision),
    .buffer_full(buffer_full), .ack_received_status(ack_received_status),
    .addr_update_needed(addr_update_needed), .start_enable(start_enable), .stop_enable(stop_enable),
    .start_seen(start_seen), .stop_seen(stop_seen), .rx_valid(rx_valid), .rx_data(rx_data));
  igm_bus_peer peer (.scl(scl_in), .sda(sda_in), .go(go), .tx_byte(tx_byte), .ack_en(ack_en),
    .stretch(stretch), .hold(hold), .scl_pull(p_scl), .sda_pull(p_sda));
  initial forever #25 clk = ~clk;
  always @(posedge scl_in) cap = {cap[7:0], sda_in};
  function automatic logic [7:0] z(input logic b);
    return {7'h00, b};
  endfunction
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: start_enable_set <= 1'b1;
      1: stop_enable_set <= 1'b1;
      2: buf_wr <= 1'b1;
      3: irq_clear <= 1'b1;
      default: write_collision_clear <= 1'b1;
    endcase
    @(posedge clk);
    {start_enable_set, stop_enable_set, buf_wr, irq_clear, write_collision_clear} <= 5'h00;
    #1;
  endtask
  task automatic wait_flag(input string nm);
    int k;
    k = 0;
    while (port_irq_flag !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
    chk(nm, 8'h01, z(port_irq_flag));
    if (k >= 3000) report_and_stop();
    pulse(3);
  endtask
  task automatic send(input igm_byte_t d, input logic nak);
    @(posedge clk);
    ack_en <= !nak;
    stretch <= nak;
    buf_wr_data <= d;
    pulse(2);
    wait_flag("byte flag");
    chk("byte on wire", d, cap[8:1]);
    chk("ack status", z(nak), z(ack_received_status));
    chk("buffer_full", 8'h00, z(buffer_full));
  endtask
  task automatic t_reset;
    chk("scl_oe", 8'h00, z(scl_oe));
    chk("sda_oe", 8'h00, z(sda_oe));
    chk("start_seen", 8'h00, z(start_seen));
    chk("line levels", 8'h00, {6'h00, scl_out, sda_out});
    $display("test reset done");
  endtask
  task automatic t_master;
    @(posedge clk);
    port_mode_sel <= 4'h8;
    port_enable <= 1'b1;
    // Bit 7 set on purpose: only the low seven bits may count
    addr_reload_reg <= 8'h83;
    pulse(0);
    pulse(2);
    chk("write_collision", 8'h01, z(write_collision));
    pulse(4);
    wait_flag("start flag");
    chk("start_seen", 8'h01, z(start_seen));
    chk("sda_oe", 8'h01, z(sda_oe));
    send(8'hA4, 1'b0);
    send(8'h5B, 1'b1);
    pulse(1);
    wait_flag("stop flag");
    chk("stop_seen", 8'h01, z(stop_seen));
    $display("test master done");
  endtask
  task automatic t_gcall;
    int n;
    @(posedge clk);
    ack_en <= 1'b0;
    stretch <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      port_mode_sel <= i[0] ? 4'h7 : 4'h6;
      general_call_en <= i < 2;
      // Last frame is a ten-bit header, not a general call
      tx_byte <= (i == 3) ? 8'hF0 : 8'h00;
      go <= 1'b1;
      cyc(2);
      go <= 1'b0;
      cyc(200);
      chk("gcall flag", z(i < 2), z(port_irq_flag));
      if (i < 2) chk("buffer_full", 8'h01, z(buffer_full));
      chk("addr_update", z(i == 3), z(addr_update_needed));
      pulse(3);
    end
    chk("rx_data", 8'h00, rx_data);
    n = 0;
    @(posedge clk);
    rx_ready <= 1'b1;
    #1;
    repeat (4) begin
      if (rx_valid === 1'b1) n++;
      cyc(1);
    end
    chk("words drained", 8'h02, n[7:0]);
    chk("rx_valid", 8'h00, z(rx_valid));
    $display("test general call done");
  endtask
  task automatic t_hold;
    @(posedge clk);
    clock_release <= 1'b0;
    cyc(20);
    chk("scl_oe before low", 8'h00, z(scl_oe));
    hold <= 1'b1;
    cyc(10);
    hold <= 1'b0;
    cyc(10);
    chk("scl_oe held", 8'h01, z(scl_oe));
    @(posedge clk);
    clock_release <= 1'b1;
    cyc(10);
    chk("scl_oe released", 8'h00, z(scl_oe));
    @(posedge clk);
    port_enable <= 1'b0;
    cyc(2);
    chk("status cleared", 8'h00, {6'h00, start_seen, stop_seen});
    $display("test clock hold done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    cyc(6);
    t_reset();
    t_master();
    t_gcall();
    t_hold();
    report_and_stop();
  end
endmodule
